/* inc/plut_defs.svh */
`ifndef PLUT_DEFS_SVH
`define PLUT_DEFS_SVH

// ------------------------------------------------------------
// register byte addresses (apb, one aligned word each)
// ------------------------------------------------------------
`define PLUT_A_CTRL 12'h000
`define PLUT_A_SELECT 12'h004
`define PLUT_A_VALUE 12'h008
`define PLUT_A_BULK_START 12'h00C
`define PLUT_A_BULK_DATA 12'h010
`define PLUT_A_STATUS 12'h014

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PLUT_CTRL_EN_BIT 0
`define PLUT_CTRL_FMT8_BIT 1
`define PLUT_ST_INIT_BIT 0
`define PLUT_ST_BULK_DONE_BIT 1
`define PLUT_ST_BPTR_LSB 16
`define PLUT_ST_BPTR_MSB 28

// ------------------------------------------------------------
// table geometry and reset values
// ------------------------------------------------------------
`define PLUT_IDX_MAX 12'hFFF
`define PLUT_DEPTH 13'h1000
`define PLUT_IDX_ZERO 12'h000
`define PLUT_BPTR_ZERO 13'h0000
`define PLUT_CTRL_RST 1'b0

`endif

/* inc/plut_pkg.sv */
package plut_pkg;

  // one pixel beat on the stream
  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } plut_pix_t;

  typedef enum logic {st_init, st_run} plut_state_t;

  // whole state of the top module
  typedef struct packed {
    plut_state_t st;
    logic [11:0] init_ptr;
    logic enable;
    logic fmt8;
    logic [11:0] sel;
    logic [11:0] last_val;
    logic [12:0] bulk_ptr;
    logic [31:0] rdata;
    logic err;
    logic p0_valid;
    logic [11:0] p0_raw;
    logic p0_use;
    logic p0_fmt8;
    plut_pix_t out;
  } plut_state_s_t;

  // read side state of the table memory
  typedef struct packed {
    logic [11:0] rdata;
  } plut_ram_s_t;

endpackage : plut_pkg

/* rtl/plut_table_ram.sv */
`timescale 1ns/1ns
`include "plut_defs.svh"

module plut_table_ram (
  input logic clk,
  input logic rstn,
  input logic we,
  input logic [11:0] waddr,
  input logic [11:0] wdata,
  input logic [11:0] raddr,
  output logic [11:0] rdata
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // no reset on the array: contents are filled by the init walk
  logic [11:0] mem [0:`PLUT_IDX_MAX];
  plut_pkg::plut_ram_s_t r;
  plut_pkg::plut_ram_s_t next_r;

  // write port, no read-during-write bypass needed
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // synchronous read, one cycle
  always_comb begin
    next_r = r;
    next_r.rdata = mem[raddr];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;

endmodule : plut_table_ram

/* rtl/plut_top.sv */
`timescale 1ns/1ns
`include "plut_defs.svh"

module plut_top (
  input logic clk,
  input logic rstn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input plut_pkg::plut_pix_t pix_in,
  output plut_pkg::plut_pix_t pix_out
);

  plut_pkg::plut_state_s_t r;
  plut_pkg::plut_state_s_t next_r;
  logic we;
  logic [11:0] waddr;
  logic [11:0] wdata;
  logic [11:0] raddr;
  logic [11:0] ram_rdata;
  logic acc_wr;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // 8-bit pixels use every sixteenth entry of the 12-bit index space
  function automatic logic [11:0] index_of(input logic [11:0] pix, input logic f8);
    index_of = f8 ? {pix[7:0], 4'h0} : pix;
  endfunction : index_of

  function automatic logic [11:0] result_of(input logic [11:0] val, input logic f8);
    result_of = f8 ? {4'h0, val[11:4]} : val;
  endfunction : result_of

  // ------------------------------------------------------------
  // table memory
  // ------------------------------------------------------------
  plut_table_ram u_ram (
    .clk(clk),
    .rstn(rstn),
    .we(we),
    .waddr(waddr),
    .wdata(wdata),
    .raddr(raddr),
    .rdata(ram_rdata)
  );

  // lookup address straight from the incoming pixel
  assign raddr = index_of(pix_in.data, r.fmt8);
  assign acc_wr = psel && penable && pwrite && !r.err;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    we = 1'b0;
    waddr = `PLUT_IDX_ZERO;
    wdata = `PLUT_IDX_ZERO;
    // identity fill after reset, 4096 cycles
    case (r.st)
      plut_pkg::st_init: begin
        we = 1'b1;
        waddr = r.init_ptr;
        wdata = r.init_ptr;
        next_r.init_ptr = r.init_ptr + 12'h001;
        if (r.init_ptr == `PLUT_IDX_MAX) begin
          next_r.st = plut_pkg::st_run;
        end
      end
      default: begin
      end
    endcase
    // setup phase: decode, latch read data and error
    if (psel && !penable) begin
      next_r.err = 1'b0;
      next_r.rdata = 32'h0000_0000;
      if (paddr == `PLUT_A_CTRL) begin
        next_r.rdata[`PLUT_CTRL_EN_BIT] = r.enable;
        next_r.rdata[`PLUT_CTRL_FMT8_BIT] = r.fmt8;
      end else if (paddr == `PLUT_A_SELECT) begin
        next_r.rdata[11:0] = r.sel;
      end else if (paddr == `PLUT_A_VALUE) begin
        next_r.rdata[11:0] = r.last_val;
        // table busy with the identity fill
        next_r.err = pwrite && (r.st != plut_pkg::st_run);
      end else if (paddr == `PLUT_A_BULK_START) begin
        next_r.err = pwrite && (r.st != plut_pkg::st_run);
      end else if (paddr == `PLUT_A_BULK_DATA) begin
        next_r.err = pwrite && ((r.st != plut_pkg::st_run) || (r.bulk_ptr == `PLUT_DEPTH));
      end else if (paddr == `PLUT_A_STATUS) begin
        next_r.rdata[`PLUT_ST_INIT_BIT] = (r.st == plut_pkg::st_init);
        next_r.rdata[`PLUT_ST_BULK_DONE_BIT] = (r.bulk_ptr == `PLUT_DEPTH);
        next_r.rdata[`PLUT_ST_BPTR_MSB:`PLUT_ST_BPTR_LSB] = r.bulk_ptr;
        next_r.err = pwrite;
      end else begin
        next_r.err = 1'b1;
      end
    end
    // access phase: writes take effect here
    if (acc_wr) begin
      if (paddr == `PLUT_A_CTRL) begin
        next_r.enable = pwdata[`PLUT_CTRL_EN_BIT];
        next_r.fmt8 = pwdata[`PLUT_CTRL_FMT8_BIT];
      end else if (paddr == `PLUT_A_SELECT) begin
        next_r.sel = pwdata[11:0];
      end else if (paddr == `PLUT_A_VALUE) begin
        // one table only, every write lands in it
        we = 1'b1;
        waddr = r.sel;
        wdata = pwdata[11:0];
        next_r.last_val = pwdata[11:0];
      end else if (paddr == `PLUT_A_BULK_START) begin
        next_r.bulk_ptr = `PLUT_BPTR_ZERO;
      end else if (paddr == `PLUT_A_BULK_DATA) begin
        we = 1'b1;
        waddr = r.bulk_ptr[11:0];
        wdata = pwdata[11:0];
        next_r.bulk_ptr = r.bulk_ptr + 13'h0001;
      end
    end
    // pixel stage 0 waits on the memory read, stage 1 selects
    next_r.p0_valid = pix_in.valid;
    next_r.p0_raw = pix_in.data;
    next_r.p0_use = r.enable;
    next_r.p0_fmt8 = r.fmt8;
    next_r.out.valid = r.p0_valid;
    // bypass is delayed too, so frame timing never shifts
    next_r.out.data = r.p0_use ? result_of(ram_rdata, r.p0_fmt8) : r.p0_raw;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.st <= plut_pkg::st_init;
      r.enable <= `PLUT_CTRL_RST;
      r.bulk_ptr <= `PLUT_DEPTH;
    end else begin
      r <= next_r;
    end
  end

  // zero-wait access phase
  assign pready = psel && penable;
  assign pslverr = psel && penable && r.err;
  assign prdata = r.rdata;
  assign pix_out = r.out;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  fixed_latency_a: assert property (pix_in.valid |-> ##2 pix_out.valid)
    else $error("pixel did not leave after two cycles");
  bypass_value_a: assert property (pix_in.valid && !r.enable |-> ##2
      pix_out.data == $past(pix_in.data, 2))
    else $error("disabled path altered the pixel");
  enable_write_a: assert property (acc_wr && paddr == `PLUT_A_CTRL |=>
      r.enable == $past(pwdata[`PLUT_CTRL_EN_BIT]))
    else $error("enable did not follow the control write");
  value_store_a: assert property (acc_wr && paddr == `PLUT_A_VALUE |->
      we && waddr == r.sel && wdata == pwdata[11:0])
    else $error("value write not stored at selected index");
  identity_fill_a: assert property (r.st == plut_pkg::st_init |-> we && wdata == waddr)
    else $error("init walk wrote a non-identity entry");
  fill_end_a: assert property (r.st == plut_pkg::st_init && r.init_ptr == `PLUT_IDX_MAX |=>
      r.st == plut_pkg::st_run && $past(we))
    else $error("init walk did not end after the last entry");
  fmt8_range_a: assert property (pix_in.valid && r.enable && r.fmt8 |-> ##2
      pix_out.data[11:8] == 4'h0)
    else $error("8-bit result exceeds 8 bits");
  bulk_step_a: assert property (acc_wr && paddr == `PLUT_A_BULK_DATA |->
      we && waddr == r.bulk_ptr[11:0] ##1 r.bulk_ptr == $past(r.bulk_ptr) + 13'h0001)
    else $error("bulk write did not advance");
  bulk_bound_a: assert property (r.bulk_ptr <= `PLUT_DEPTH)
    else $error("bulk pointer beyond the table");

  enabled_lookup_c: cover property (pix_in.valid && r.enable && !r.fmt8 ##2 pix_out.valid);
  fmt8_lookup_c: cover property (pix_in.valid && r.enable && r.fmt8 ##2 pix_out.valid);
  bulk_done_c: cover property (acc_wr && paddr == `PLUT_A_BULK_DATA &&
      r.bulk_ptr == 13'h0FFF);
  refused_c: cover property (pslverr);

endmodule : plut_top

/* tb/plut_pix_src.sv */
`timescale 1ns/1ns

// ------------------------------------------------------------
// upstream pixel source
// ------------------------------------------------------------
module plut_pix_src (
  input logic clk,
  input logic rstn,
  input logic req,
  input logic [11:0] req_data,
  output plut_pkg::plut_pix_t pix
);
  // one beat per request; idle data flips so a stale beat never looks valid
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pix <= '0;
    end else begin
      pix.valid <= req;
      pix.data <= req ? req_data : ~pix.data;
    end
  end
endmodule : plut_pix_src

/* tb/testbench.sv */
`timescale 1ns/1ns

// ------------------------------------------------------------
// bench signals and instances
// ------------------------------------------------------------
module testbench;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, req, er;
  logic [11:0] paddr, rdat, d, v;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] tbl [4096];
  plut_pkg::plut_pix_t pix_in, pix_out;
  int num_errors, total_checks, i, k, n;

  plut_top dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_in(pix_in), .pix_out(pix_out));
  plut_pix_src src (.clk(clk), .rstn(rstn), .req(req), .req_data(rdat),
    .pix(pix_in));

  // 4 ns period
  always #2 clk = ~clk;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      close_out;
    end
  endtask : apb

  // one pixel through the block; the source adds one cycle
  task automatic px(input logic [11:0] di, input logic [11:0] e);
    @(posedge clk);
    req <= 1'b1;
    rdat <= di;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    #1 chk({31'h0, pix_out.valid}, 32'h0);
    @(posedge clk);
    #1 chk({31'h0, pix_out.valid}, 32'h1);
    chk({20'h0, pix_out.data}, {20'h0, e});
  endtask : px

  // main sequence
  initial begin
    clk = 0;
    rstn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    req = 0;
    rdat = '0;
    void'($urandom(32'h147C));
    for (i = 0; i < 4096; i++) tbl[i] = i[11:0];
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0);
    // table writes are refused while the identity fill still runs
    apb(1, 12'h008, 32'h5A5);
    chk({31'h0, er}, 32'h1);
    n = 0;
    do begin
      apb(0, 12'h014, 0);
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      num_errors++;
      close_out;
    end
    for (k = 0; k < 4; k++) begin
      d = 12'($urandom);
      px(d, d);
    end
    apb(1, 12'h000, 32'h1);
    for (k = 0; k < 4; k++) begin
      d = 12'($urandom);
      px(d, tbl[d]);
    end
    // index then value; both ends of the index range first
    for (k = 0; k < 6; k++) begin
      d = (k < 2) ? {12{k[0]}} : 12'($urandom);
      v = (k < 2) ? ~d : 12'($urandom);
      apb(1, 12'h004, {20'h0, d});
      apb(1, 12'h008, {20'h0, v});
      apb(0, 12'h004, 0);
      chk(rd, {20'h0, d});
      apb(0, 12'h008, 0);
      chk(rd, {20'h0, v});
      tbl[d] = v;
      px(d, tbl[d]);
    end
    // 8-bit pixels use every sixteenth entry
    apb(1, 12'h000, 32'h3);
    for (k = 0; k < 4; k++) begin
      d = {4'h0, 8'($urandom)};
      px(d, {4'h0, tbl[{d[7:0], 4'h0}][11:4]});
    end
    apb(1, 12'h000, 32'h1);
    apb(1, 12'h00C, 0);
    for (i = 0; i < 4096; i++) begin
      tbl[i] = ~i[11:0];
      apb(1, 12'h010, {20'h0, tbl[i]});
    end
    apb(0, 12'h014, 0);
    chk(rd[28:0] & 29'h1FFF0002, 29'h10000002);
    apb(1, 12'h010, 0);
    chk({31'h0, er}, 32'h1);
    for (k = 0; k < 6; k++) begin
      d = 12'($urandom);
      px(d, tbl[d]);
    end
    apb(1, 12'h000, 0);
    d = 12'($urandom);
    px(d, d);
    // no table selector exists: a spare address is refused
    apb(0, 12'h020, 0);
    chk({er, rd[30:0]}, 32'h80000000);
    // reset in mid-run: enable clears, fill restarts, bulk reads done
    apb(1, 12'h000, 32'h1);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 chk({19'h0, pix_out}, 32'h0);
    apb(0, 12'h000, 0);
    chk(rd, 32'h0);
    apb(0, 12'h014, 0);
    chk(rd & 32'h1FFF0003, 32'h10000003);
    close_out;
  end
endmodule : testbench
